// ---- inc/sram_host_cfg.svh ----
// timing counts and sizes for the static memory host controller
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH

`define ADDR_W 15
`define DATA_W 8

`define CLK_PS 4000
`define CYC(t) ((((t) + `CLK_PS - 1) / `CLK_PS) < 1 ? 1 : \
  (((t) + `CLK_PS - 1) / `CLK_PS))
`define MAX2(a, b) ((a) > (b) ? (a) : (b))

`define T_ADDR_SETUP_PS 8000
`define T_DATA_SETUP_PS 6500
`define T_STROBE_GATE_HIGH_PS 7000
`define T_STROBE_GATE_LOW_PS 10000
`define T_STROBE_FLOAT_PS 3500
`define T_READ_ACCESS_PS 10000
`define T_OUT_FLOAT_PS 5000
`define T_RECOVERY_PS 10000

`define ADDR_SETUP_CYC `CYC(`T_ADDR_SETUP_PS)
`define DATA_SETUP_CYC `CYC(`T_DATA_SETUP_PS)
`define FLOAT_CYC `CYC(`T_STROBE_FLOAT_PS)
`define WR_GH_CYC `MAX2(`CYC(`T_STROBE_GATE_HIGH_PS), \
  `MAX2(`DATA_SETUP_CYC, `ADDR_SETUP_CYC))
`define WR_GL_CYC `MAX2(`CYC(`T_STROBE_GATE_LOW_PS), \
  `MAX2(`FLOAT_CYC + `DATA_SETUP_CYC, `ADDR_SETUP_CYC))
`define RD_ACC_CYC `CYC(`T_READ_ACCESS_PS)
`define TURN_CYC `CYC(`T_OUT_FLOAT_PS)
`define RECOV_CYC `CYC(`T_RECOVERY_PS)

`endif

// ---- inc/sram_host_pkg.sv ----
// types shared by the static memory host controller
`include "sram_host_cfg.svh"
package sram_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR,
    ST_WEND,
    ST_RD,
    ST_TURN,
    ST_SLEEP,
    ST_RECOV
  } state_e;

  typedef struct packed {
    logic wr;
    logic gate_low;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`ADDR_W-1:0] addr;
  } pins_s;

endpackage

// ---- hdl/sram_dq_sync.sv ----
// multi-stage synchroniser for the data pins read back from the memory
`timescale 1ns/1ps
module sram_dq_sync #(
  parameter int WIDTH = 8,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_r [STAGES];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign q = stage_r[STAGES-1];
endmodule

// ---- hdl/sram_host.sv ----
// host controller driving an asynchronous static memory through its pins
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module sram_host #(
  parameter int SYNC_N = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // user request
  input wire logic REQ_VALID,
  input wire sram_host_pkg::req_s REQ,
  output logic REQ_READY,
  // user read answer
  output logic RESP_VALID,
  output logic [`DATA_W-1:0] RESP_DATA,
  // retention handshake
  input wire logic SLEEP_REQ,
  output logic SLEEP_ACK,
  // memory control and address pins
  output sram_host_pkg::pins_s MEM,
  // memory data pins
  output logic [`DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic [`DATA_W-1:0] DQ_IN
);
  import sram_host_pkg::*;

  localparam logic [3:0] WR_GH = 4'(`WR_GH_CYC);
  localparam logic [3:0] WR_GL = 4'(`WR_GL_CYC);
  localparam logic [3:0] FLOAT = 4'(`FLOAT_CYC);
  localparam logic [3:0] RD_CNT = 4'(`RD_ACC_CYC + SYNC_N);
  localparam logic [3:0] TURN = 4'(`TURN_CYC);
  localparam logic [3:0] RECOV = 4'(`RECOV_CYC);
  localparam int RD_LAT = `RD_ACC_CYC + SYNC_N;

  state_e st_r;
  state_e st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  req_s req_r;
  pins_s pins_r;
  logic [`DATA_W-1:0] dq_out_r;
  logic dq_oe_n_r;
  logic [`DATA_W-1:0] dq_sync;
  logic ready_r;
  logic resp_valid_r;
  logic [`DATA_W-1:0] resp_data_r;
  logic ack_r;
  logic take;
  logic done;

  sram_dq_sync #(
    .WIDTH(`DATA_W),
    .STAGES(SYNC_N)
  ) u_sync (
    .clk(CLK),
    .rstn(RSTN),
    .d(DQ_IN),
    .q(dq_sync)
  );

  assign take = REQ_VALID && ready_r;
  assign done = (cnt_r == 4'h0);

  // sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take) begin
          st_nxt = REQ.wr ? ST_WR : ST_RD;
        end else if (SLEEP_REQ) begin
          st_nxt = ST_SLEEP;
        end
      end
      ST_WR: begin
        if (done) begin
          st_nxt = ST_WEND;
        end
      end
      ST_WEND: st_nxt = ST_IDLE;
      ST_RD: begin
        if (done) begin
          st_nxt = ST_TURN;
        end
      end
      ST_TURN: begin
        if (done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!SLEEP_REQ) begin
          st_nxt = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (done) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // interval counter, loaded on entry to a timed state
  always_comb begin
    cnt_nxt = done ? 4'h0 : cnt_r - 4'h1;
    if (st_r != st_nxt) begin
      case (st_nxt)
        ST_WR: cnt_nxt = REQ.gate_low ? WR_GL - 4'h1 : WR_GH - 4'h1;
        ST_RD: cnt_nxt = RD_CNT - 4'h1;
        ST_TURN: cnt_nxt = TURN - 4'h1;
        ST_RECOV: cnt_nxt = RECOV - 4'h1;
        default: cnt_nxt = 4'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_r <= '0;
    end else if (take) begin
      req_r <= REQ;
    end
  end

  // control and address pins
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pins_r.ce_n <= 1'b1;
      pins_r.oe_n <= 1'b1;
      pins_r.we_n <= 1'b1;
      pins_r.addr <= '0;
    end else if (take) begin
      pins_r.addr <= REQ.addr;
      pins_r.ce_n <= 1'b0;
      pins_r.we_n <= !REQ.wr;
      pins_r.oe_n <= REQ.wr ? !REQ.gate_low : 1'b0;
    end else if ((st_r == ST_WR || st_r == ST_RD) && done) begin
      // select and strobe end on the same edge
      pins_r.ce_n <= 1'b1;
      pins_r.we_n <= 1'b1;
      pins_r.oe_n <= 1'b1;
    end
  end

  // write data drive
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_out_r <= '0;
      dq_oe_n_r <= 1'b1;
    end else if (take && REQ.wr) begin
      dq_out_r <= REQ.wdata;
      dq_oe_n_r <= REQ.gate_low;
    end else if (st_r == ST_WR && req_r.gate_low &&
                 cnt_r <= WR_GL - FLOAT) begin
      // memory has floated its outputs by now
      dq_oe_n_r <= 1'b0;
    end else if (st_r == ST_WEND) begin
      dq_oe_n_r <= 1'b1;
    end
  end

  // read answer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      resp_valid_r <= 1'b0;
      resp_data_r <= '0;
    end else begin
      resp_valid_r <= (st_r == ST_RD) && done;
      if ((st_r == ST_RD) && done) begin
        resp_data_r <= dq_sync;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ready_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      ready_r <= (st_nxt == ST_IDLE) && !SLEEP_REQ;
      ack_r <= (st_nxt == ST_SLEEP);
    end
  end

  assign REQ_READY = ready_r;
  assign RESP_VALID = resp_valid_r;
  assign RESP_DATA = resp_data_r;
  assign SLEEP_ACK = ack_r;
  assign MEM = pins_r;
  assign DQ_OUT = dq_out_r;
  assign DQ_OE_N = dq_oe_n_r;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_write_start;
    !pins_r.we_n |-> !pins_r.ce_n;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("strobe low without select");

  property p_end_together;
    $rose(pins_r.we_n) |-> $rose(pins_r.ce_n);
  endproperty
  a_end_together: assert property (p_end_together)
    else $error("write end edge not shared by select and strobe");

  property p_data_setup;
    $rose(pins_r.we_n) |-> !$past(dq_oe_n_r) && !$past(dq_oe_n_r, 2) &&
      $past(dq_out_r) == $past(dq_out_r, 2);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not stable two cycles before end");

  property p_data_hold;
    $rose(pins_r.we_n) |-> !dq_oe_n_r && $stable(dq_out_r);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data dropped before end edge");

  property p_addr_setup;
    $rose(pins_r.we_n) |-> $stable(pins_r.addr) &&
      $past(pins_r.addr) == $past(pins_r.addr, 2);
  endproperty
  a_addr_setup: assert property (p_addr_setup)
    else $error("address not stable before write end");

  property p_addr_hold;
    $changed(pins_r.addr) |-> $past(pins_r.we_n) && $past(pins_r.ce_n);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during an access");

  property p_width_gate_high;
    $fell(pins_r.we_n) && pins_r.oe_n |-> (!pins_r.we_n)[*2];
  endproperty
  a_width_gate_high: assert property (p_width_gate_high)
    else $error("strobe too short with gate high");

  property p_width_gate_low;
    $fell(pins_r.we_n) && !pins_r.oe_n |-> (!pins_r.we_n)[*3];
  endproperty
  a_width_gate_low: assert property (p_width_gate_low)
    else $error("strobe too short with gate low");

  property p_read_strobe;
    st_r == ST_RD |-> pins_r.we_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("strobe low in a read");

  property p_read_latency;
    $fell(pins_r.ce_n) && pins_r.we_n |-> ##RD_LAT resp_valid_r;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not at fixed latency");

  property p_read_addr;
    !pins_r.ce_n && !$past(pins_r.ce_n) |-> $stable(pins_r.addr);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("address changed after select fell");

  property p_retention;
    ack_r |-> pins_r.ce_n && pins_r.we_n;
  endproperty
  a_retention: assert property (p_retention)
    else $error("retention granted while selected");

  property p_no_contention;
    !pins_r.ce_n && !pins_r.oe_n && pins_r.we_n |-> dq_oe_n_r;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("host drives data during a read");

endmodule

// ---- verification/sram_mem_model.sv ----
// behavioural asynchronous static memory answering the host pins
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module sram_mem_model (
  // control, address and data from the host
  input wire sram_host_pkg::pins_s mem,
  input wire logic [`DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  // access speed select
  input wire logic slow,
  // data pins back to the host
  output logic [`DATA_W-1:0] dq_in
);
  import sram_host_pkg::*;
  logic [`DATA_W-1:0] store [0:(1<<`ADDR_W)-1];
  logic [`DATA_W-1:0] wd;
  logic [`ADDR_W-1:0] wa;
  wire wr_on = !mem.ce_n && !mem.we_n;
  initial dq_in = 8'h5a;
  // latch address and data only inside the select and strobe overlap
  always @(mem, dq_out, dq_oe_n) begin
    if (wr_on && !dq_oe_n) begin
      wa = mem.addr;
      wd = dq_out;
    end
  end
  always @(negedge wr_on) begin
    store[wa] = wd;
  end
  // released pins show the inverse of the last value, not a stale copy
  always @(mem) begin
    dq_in <= ~dq_in;
    if (!mem.ce_n && !mem.oe_n && mem.we_n) begin
      dq_in <= #(slow ? 9.5 : 2.0) store[mem.addr];
    end
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`include "sram_host_cfg.svh"
module testbench;
  import sram_host_pkg::*;
  logic CLK = 0, RSTN = 0, REQ_VALID = 0, SLEEP_REQ = 0, slow = 0;
  req_s REQ = '0;
  logic REQ_READY, RESP_VALID, SLEEP_ACK, DQ_OE_N;
  logic [`DATA_W-1:0] RESP_DATA, DQ_OUT, DQ_IN;
  pins_s MEM;
  int mismatches = 0, checked = 0, wlen = 0, dlen = 0;
  logic woe;
  logic [`ADDR_W-1:0] wadr;
  logic [`DATA_W-1:0] ref_mem [int];
  logic [`ADDR_W-1:0] addrs [$];
  sram_host dut_u (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .RESP_VALID(RESP_VALID),
    .RESP_DATA(RESP_DATA), .SLEEP_REQ(SLEEP_REQ), .SLEEP_ACK(SLEEP_ACK),
    .MEM(MEM), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .DQ_IN(DQ_IN));
  sram_mem_model mem_u (.mem(MEM), .dq_out(DQ_OUT), .dq_oe_n(DQ_OE_N),
    .slow(slow), .dq_in(DQ_IN));
  initial begin
    forever #2 CLK = ~CLK;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one request held until taken, then its first pin cycle checked
  task automatic issue(logic wr, logic gl, logic [14:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{wr, gl, a, d};
    do begin
      @(negedge CLK);
      n++;
    end while (REQ_READY !== 1'b1 && n < 50);
    check("ready_wait", n < 50, 1);
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    @(negedge CLK);
    check("sel", MEM.ce_n, 0);
    check("strobe", MEM.we_n, !wr);
    check("addr", MEM.addr, a);
    if (wr) begin
      ref_mem[a] = d;
      check("gate", MEM.oe_n, !gl);
      check("wdata", DQ_OUT, d);
    end else begin
      check("gate", MEM.oe_n, 0);
      n = 0;
      while (RESP_VALID !== 1'b1 && n < 20) begin
        @(negedge CLK);
        n++;
      end
      check("rd_lat", n, 5);
      check("rd_data", RESP_DATA, ref_mem[a]);
    end
  endtask
  // pin monitor: strobe width, address and data setup, bus ownership
  always @(negedge CLK) begin
    if (RSTN) begin
      if (!MEM.ce_n && !MEM.oe_n && MEM.we_n) begin
        check("no_clash", DQ_OE_N, 1);
      end
      if (SLEEP_ACK === 1'b1) begin
        check("sleep_sel", MEM.ce_n, 1);
      end
      if (MEM.we_n === 1'b0) begin
        wlen++;
        if (wlen == 1) begin
          wadr = MEM.addr;
          woe = MEM.oe_n;
        end
        check("wr_addr", MEM.addr, wadr);
        dlen = DQ_OE_N ? 0 : dlen + 1;
      end else if (wlen > 0) begin
        check("wr_width", 4 * wlen >= (woe ? 7 : 10), 1);
        check("wr_setup", 8 * dlen >= 13, 1);
        check("wr_end", MEM.ce_n, 1);
        wlen = 0;
        dlen = 0;
      end
    end
  end
  initial begin
    #50000;
    mismatches++;
    summarize();
  end
  initial begin
    logic [14:0] a;
    void'($urandom(62));
    addrs = '{15'h0000, 15'h7fff};
    repeat (10) begin
      @(posedge CLK);
    end
    RSTN <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (i >= 2) begin
        addrs.push_back(15'($urandom));
      end
      issue(1, i[0], addrs[i], 8'($urandom));
    end
    for (int i = 11; i >= 0; i--) begin
      slow <= i[1];
      issue(0, 0, addrs[i], 8'h00);
    end
    // reset again in mid-run, during the read turnaround
    @(posedge CLK);
    RSTN <= 1'b0;
    @(negedge CLK);
    check("rst_sel", MEM.ce_n, 1);
    check("rst_strobe", MEM.we_n, 1);
    check("rst_drive", DQ_OE_N, 1);
    check("rst_rdy", REQ_READY, 0);
    repeat (2) begin
      @(posedge CLK);
    end
    RSTN <= 1'b1;
    @(posedge CLK);
    SLEEP_REQ <= 1'b1;
    repeat (4) begin
      @(negedge CLK);
    end
    check("sleep_ack", SLEEP_ACK, 1);
    check("sleep_rdy", REQ_READY, 0);
    @(posedge CLK);
    SLEEP_REQ <= 1'b0;
    a = addrs[3];
    issue(0, 0, a, 8'h00);
    issue(1, 1, a, 8'h3c);
    issue(0, 0, a, 8'h00);
    summarize();
  end
endmodule
